// File: core/fbsr_pkg.sv
// package for the four-stage parallel-access shift register
package fbsr_pkg;
    // ------------------------------------------------------------
    // widths and stage positions
    // ------------------------------------------------------------
    localparam int FBSR_WIDTH = 4;    // number of stages
    localparam int FBSR_STAGE0 = 0;   // entry stage for serial data
    localparam int FBSR_STAGE3 = 3;   // last stage of a right shift
    localparam logic [3:0] FBSR_STAGES_RST = 4'h0; // stages after reset
    localparam logic [2:0] FBSR_SYNC_RST = 3'h0;   // sync flops after reset

    // ------------------------------------------------------------
    // operations chosen on each clock
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FBSR_OP_HOLD = 2'b00,
        FBSR_OP_LOAD = 2'b01,
        FBSR_OP_SHIFT = 2'b10
    } fbsr_op_t;

    // synchronised pin levels travel together
    typedef struct packed {
        logic mode_select;        // high selects load or left shift
        logic load_left_strobe;   // load / left-shift strobe
        logic right_shift_strobe; // right-shift strobe
    } fbsr_ctrl_t;
endpackage

// File: core/fbsr_shift4.sv
// four-stage register: parallel load, shift right, shift left by wiring
module fbsr_shift4
    import fbsr_pkg::*;
#(
    parameter int WIDTH = FBSR_WIDTH
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    // board control pins, asynchronous to ref_clk_in
    input wire logic mode_select_in,
    input wire logic load_left_strobe_in,
    input wire logic right_shift_strobe_in,
    // board data pins
    input wire logic serial_in,
    input wire logic [WIDTH-1:0] par_in,
    // stage outputs
    output logic [WIDTH-1:0] stage_out
);
    // ------------------------------------------------------------
    // timing overview
    // ------------------------------------------------------------
    // every board pin passes two flops before any logic reads it, so a
    // strobe edge reaches the stages three rising clock edges later;
    // latency was traded for safety: an edge close to a clock edge
    // can never split one operation into two
    // a strobe must rest high and low for a few clocks each, since a
    // pulse shorter than one clock period may slip between samples
    // resetn_in exists only so that simulation starts from known
    // stages; the register itself keeps whatever it last took

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    fbsr_ctrl_t ctrl_meta;       // first flop, read only by ctrl_sync
    fbsr_ctrl_t ctrl_sync;       // second flop, safe to use
    fbsr_ctrl_t ctrl_prev;       // one more stage for edge detection
    logic [WIDTH:0] data_meta;   // serial and parallel, first flop
    logic [WIDTH:0] data_sync;   // serial and parallel, second flop
    fbsr_ctrl_t next_ctrl_meta;
    fbsr_ctrl_t next_ctrl_sync;
    fbsr_ctrl_t next_ctrl_prev;
    logic [WIDTH:0] next_data_meta;
    logic [WIDTH:0] next_data_sync;

    // next values of the synchroniser chain
    always_comb begin
        next_ctrl_meta = '{mode_select: mode_select_in,
                           load_left_strobe: load_left_strobe_in,
                           right_shift_strobe: right_shift_strobe_in};
        next_ctrl_sync = ctrl_meta;
        next_ctrl_prev = ctrl_sync;
        next_data_meta = {serial_in, par_in};
        next_data_sync = data_meta;
    end

    // register the chain; the reset only gives simulation a clean start
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_meta <= FBSR_SYNC_RST;
            ctrl_sync <= FBSR_SYNC_RST;
            ctrl_prev <= FBSR_SYNC_RST;
            data_meta <= '0;
            data_sync <= '0;
        end else begin
            ctrl_meta <= next_ctrl_meta;
            ctrl_sync <= next_ctrl_sync;
            ctrl_prev <= next_ctrl_prev;
            data_meta <= next_data_meta;
            data_sync <= next_data_sync;
        end
    end

    // ------------------------------------------------------------
    // operation select
    // ------------------------------------------------------------
    // data travels with the control through equal two-flop chains, so
    // data steady before the strobe falls is what gets captured
    function automatic logic fell(input logic prev, input logic now);
        return prev & ~now;
    endfunction

    fbsr_op_t op;                // operation for this clock
    logic load_fall;             // falling edge of load strobe
    logic shift_fall;            // falling edge of right strobe

    // a strobe only counts when the mode selects it; mode is taken at
    // the edge, so a mode change with steady strobes does nothing
    always_comb begin
        load_fall = fell(ctrl_prev.load_left_strobe,
                         ctrl_sync.load_left_strobe);
        shift_fall = fell(ctrl_prev.right_shift_strobe,
                          ctrl_sync.right_shift_strobe);
        // no selected edge leaves the stages alone
        op = FBSR_OP_HOLD;
        if (ctrl_sync.mode_select) begin
            // mode high: only the load strobe may act, so serial data
            // and the right strobe are shut out here
            if (load_fall) begin
                op = FBSR_OP_LOAD;
            end
        end else if (shift_fall) begin
            // mode low: only the right strobe may act
            op = FBSR_OP_SHIFT;
        end
    end

    // ------------------------------------------------------------
    // stage storage
    // ------------------------------------------------------------
    logic [WIDTH-1:0] stages;    // stage0 is bit 0
    logic [WIDTH-1:0] next_stages;

    // load takes par as-is (left shift comes from board wiring);
    // shift right reads old stage values, so one position per edge
    always_comb begin
        next_stages = stages;
        case (op)
            FBSR_OP_LOAD: begin
                // every stage follows its own parallel pin
                next_stages = data_sync[WIDTH-1:0];
            end
            FBSR_OP_SHIFT: begin
                // stage0 takes the serial pin, the rest move up one
                next_stages = {stages[WIDTH-2:0],
                               data_sync[WIDTH]};
            end
            default: begin
                // hold: nothing new enters
                next_stages = stages;
            end
        endcase
    end

    // the pin device has no reset; resetn_in only defines sim start
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stages <= WIDTH'(FBSR_STAGES_RST);
        end else begin
            stages <= next_stages;
        end
    end

    // outputs come straight from the stage flops, no logic after them
    assign stage_out = stages;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // every check shares the clock and reset of the logic it watches
    a_load_takes_par: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (ctrl_sync.mode_select && load_fall)
        |=> stage_out == $past(data_sync[WIDTH-1:0]))
        else $error("load did not capture parallel inputs");

    a_shift_right: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (!ctrl_sync.mode_select && shift_fall)
        |=> stage_out == {$past(stages[WIDTH-2:0]),
                          $past(data_sync[WIDTH])})
        else $error("right shift moved wrong data");

    // with mode high stage0 may only keep its value or take par0;
    // the serial pin has no path in
    a_serial_blocked: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ctrl_sync.mode_select
        |=> (stage_out[FBSR_STAGE0] == $past(stages[FBSR_STAGE0])
             || stage_out[FBSR_STAGE0] == $past(data_sync[FBSR_STAGE0])))
        else $error("serial entered under mode high");

    // no edge on either strobe, nothing moves
    a_no_edge_hold: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (!load_fall && !shift_fall) |=> $stable(stage_out))
        else $error("stages changed without an edge");

    a_wrong_strobe: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (ctrl_sync.mode_select && !load_fall) |=> $stable(stage_out))
        else $error("unselected strobe changed stages");

    // mode low: a load strobe edge by itself must leave stages alone
    a_load_ignored: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (!ctrl_sync.mode_select && !shift_fall) |=> $stable(stage_out))
        else $error("load strobe acted under mode low");

    // steady strobes form no edge, whatever mode does
    a_mode_only: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        ($changed(ctrl_sync.mode_select)
         && $stable(ctrl_sync.load_left_strobe)
         && $stable(ctrl_sync.right_shift_strobe)) |=> $stable(stage_out))
        else $error("mode change altered stages");

    // stage3 must show the old stage2, never anything further back
    a_shift_one_pos: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (op == FBSR_OP_SHIFT) |=> stage_out[FBSR_STAGE3]
            == $past(stages[FBSR_STAGE3-1]))
        else $error("shift advanced more than one place");

    // three samples back: first flop, second flop, then edge compare
    a_load_two_flops: assert property (
        @(posedge ref_clk_in) disable iff (!resetn_in)
        (op == FBSR_OP_LOAD) |=> stage_out[FBSR_STAGE0]
            == $past(par_in[FBSR_STAGE0], 3))
        else $error("load bit not the synchronised pin level");
endmodule

// File: tb/fbsr_board.sv
// board-side model that drives the register pins
module fbsr_board
    import fbsr_pkg::*;
(
    // clock and stage feedback
    input wire logic clk_in,
    input wire logic [3:0] stage_in,
    // pins toward the register
    output logic mode_out,
    output logic load_out,
    output logic right_out,
    output logic serial_out,
    output logic [3:0] par_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wired; // left-shift feedback wiring in place
    logic [3:0] data; // levels offered on the parallel pins
    // feedback wiring; the new left bit rides on par3
    assign par_out = wired ? {data[3], stage_in[3:1]} : data;
    // pin changes made by the tasks land on falling edges
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // both strobes fall together, then pins rest
    task automatic drop();
        load_out = 1'h0;
        right_out = 1'h0;
        wait_n(6);
    endtask
    // mode and data settle while strobes are low
    task automatic op(input logic m, l, r, w, s, input logic [3:0] d);
        mode_out = m;
        wired = w;
        serial_out = s;
        data = d;
        wait_n(3);
        load_out = l;
        right_out = r;
        wait_n(3);
        drop();
    endtask
    // toggle mode with strobes parked; ends with mode low
    task automatic wiggle(input logic st);
        mode_out = 1'h0;
        serial_out = 1'h1;
        load_out = st;
        right_out = st;
        wait_n(3);
        repeat (4) begin
            mode_out = ~mode_out;
            wait_n(3);
        end
    endtask
    initial begin
        {mode_out, load_out, right_out, serial_out, wired} = 5'h00;
        data = 4'h0;
    end
endmodule

// File: tb/fbsr_shift4_test.sv
// self-checking bench for the four-stage shift register
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("ERROR %0t stage mismatch", $time); end end
module fbsr_shift4_test
    import fbsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'h0;
    logic resetn_in = 1'h0;
    logic mode, load, right, serial;
    logic [3:0] par, stage, exp; // exp is the bench's own model
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    fbsr_board b (.clk_in(ref_clk_in), .stage_in(stage), .mode_out(mode),
        .load_out(load), .right_out(right), .serial_out(serial),
        .par_out(par));
    fbsr_shift4 dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .mode_select_in(mode), .load_left_strobe_in(load),
        .right_shift_strobe_in(right), .serial_in(serial),
        .par_in(par), .stage_out(stage));
    // verdict and end of run
    task automatic results();
        if (errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard, well beyond the roughly two hundred cycles needed
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end
    task automatic t_load();
        b.op(1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 4'ha);
        `CHK(stage, 4'ha)
        b.op(1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 4'h5);
        `CHK(stage, 4'h5)
        exp = 4'h5;
    endtask
    // odd steps tie the load strobe in as well
    task automatic t_right();
        for (int i = 0; i < 4; i++) begin
            b.op(1'h0, i[0], 1'h1, 1'h0, i < 2, 4'hf);
            exp = {exp[2:0], i < 2};
            `CHK(stage, exp)
        end
    endtask
    task automatic t_left();
        for (int i = 0; i < 3; i++) begin
            b.op(1'h1, 1'h1, i[0], 1'h1, 1'h1, {i[0], 3'h0});
            exp = {i[0], exp[3:1]};
            `CHK(stage, exp)
        end
    endtask
    task automatic t_ignore();
        b.op(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 4'h0);
        `CHK(stage, exp)
        b.op(1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 4'h0);
        `CHK(stage, exp)
    endtask
    task automatic t_hold();
        b.wait_n(20);
        `CHK(stage, exp)
        b.wiggle(1'h0);
        `CHK(stage, exp)
        b.drop();
        b.wiggle(1'h1);
        `CHK(stage, exp)
        b.drop();
        exp = {exp[2:0], 1'h1};
        `CHK(stage, exp)
    endtask
    // hold reset three cycles, then stages must read the cleared value
    task automatic t_reset();
        repeat (3) @(negedge ref_clk_in);
        resetn_in = 1'h1;
        `CHK(stage, FBSR_STAGES_RST)
    endtask
    initial begin
        t_reset();
        t_load();
        t_right();
        t_left();
        t_ignore();
        t_hold();
        results();
    end
endmodule
